// ### block_move_pkg.sv
// Purpose: shared constants for the block move sequencer
// Assumes: one processor state equals one core_clk cycle
// Notes:   state counts hold for on-chip operands and code
`default_nettype none
package block_move_pkg;
    // widths of the general registers touched by the move
    localparam int ADDR_W         = 16;
    localparam int DATA_W         = 8;
    localparam int COUNT_W        = 16;
    localparam int COUNT_LOW_W    = 8;
    // fixed overhead, split into a leading and a trailing part
    localparam int PRE_STATES     = 4;
    localparam int POST_STATES    = 4;
    localparam int OVERHEAD_STATES = PRE_STATES + POST_STATES;
    // states spent on each byte moved
    localparam int BYTE_STATES    = 4;
    // depth of the byte buffer between read and write
    localparam int FIFO_DEPTH     = 8;
    // width of the overhead phase counter
    localparam int PHASE_W        = 3;
    // pointer and counter step per byte
    localparam logic [ADDR_W-1:0]  PTR_STEP   = 16'h0001;
    localparam logic [COUNT_W-1:0] COUNT_STEP = 16'h0001;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;
    // reset value of pointers and counters
    localparam logic [ADDR_W-1:0]  PTR_RESET  = 16'h0000;
endpackage
`default_nettype wire

// ### byte_fifo.sv
// Purpose: small synchronous fifo for moved bytes
// Assumes: single clock, push and pop may coincide
// Notes:   full and empty come from an occupancy count
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk,  // state clock
    input  wire logic             nrst,      // async reset, low
    input  wire logic             in_valid,  // push request
    output logic                  in_ready,  // room for a word
    input  wire logic [WIDTH-1:0] in_data,   // pushed word
    output logic                  out_valid, // word available
    input  wire logic             out_ready, // pop request
    output logic [WIDTH-1:0]      out_data   // oldest word
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST   = (PW)'(DEPTH - 1);

    logic [WIDTH-1:0] store [DEPTH];  // word storage
    logic [PW-1:0]    wr_ptr;         // next slot to fill
    logic [PW-1:0]    rd_ptr;         // oldest slot
    logic [PW:0]      fill;           // words held
    logic             push;           // accepted push
    logic             pop;            // accepted pop

    // wraps a pointer; depth need not be a power of two
    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == LAST) ? '0 : p + 1'b1;
    endfunction

    assign in_ready  = (fill != FULL_CNT);
    assign out_valid = (fill != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_ready && out_valid;
    assign out_data  = store[rd_ptr];

    // storage has no reset; only filled slots are ever read
    always_ff @(posedge core_clk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else begin
            if (push) begin
                wr_ptr <= bump(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= bump(rd_ptr);
            end
            if (push && !pop) begin
                fill <= fill + 1'b1;
            end else if (pop && !push) begin
                fill <= fill - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### move_counter.sv
// Purpose: loadable down counter with zero detect
// Assumes: load wins over decrement
// Notes:   narrow mode counts only the low byte
`timescale 1ns/1ps
`default_nettype none
module move_counter #(
    parameter int WIDTH = 16,
    parameter int LOW_W = 8
) (
    input  wire logic             core_clk,  // state clock
    input  wire logic             nrst,      // async reset, low
    input  wire logic             load,      // take load_value
    input  wire logic [WIDTH-1:0] load_value,// initial count
    input  wire logic             narrow,    // low byte only
    input  wire logic             dec,       // one byte moved
    output logic [WIDTH-1:0]      value,     // present count
    output logic                  is_zero    // active part is zero
);
    // the upper byte is kept untouched in narrow mode
    assign is_zero = narrow ? (value[LOW_W-1:0] == '0) : (value == '0);

    // count register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            value <= '0;
        end else if (load) begin
            value <= load_value;
        end else if (dec && narrow) begin
            value[LOW_W-1:0] <= value[LOW_W-1:0] - 1'b1;
        end else if (dec) begin
            value <= value - 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### block_move_sequencer.sv
// Purpose: sequencer for the memory to memory block move
// Assumes: single cycle on-chip memory; decode gives one start pulse
// Notes:   slow memory stretches the byte states, not the overhead
//          byte form never touches the upper count byte
//
// Behaviour
// - byte form loops while count_low_byte nonzero
// - word form loops while count_word nonzero
// - per byte: pointers up one, counter down
// - zero count: no transfer, pointers unchanged
// - takes eight plus four states per byte
// - state count holds for on-chip operands

`timescale 1ns/1ps
`default_nettype none

module block_move_sequencer
    import block_move_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic               core_clk,      // state clock
    input  wire logic               nrst,          // async reset, low

    // instruction decode and register file side
    input  wire logic               start,         // begin move, pulse
    input  wire logic               word_form,     // 1 word, 0 byte form
    input  wire logic [COUNT_W-1:0] count_word_in, // counter register
    input  wire logic [ADDR_W-1:0]  src_in,        // source_pointer
    input  wire logic [ADDR_W-1:0]  dst_in,        // dest_pointer
    output logic                    busy,          // move in progress
    output logic                    done,          // last state, pulse
    output logic [COUNT_W-1:0]      count_word,    // updated counter
    output logic [ADDR_W-1:0]       source_pointer,// updated source
    output logic [ADDR_W-1:0]       dest_pointer,  // updated dest

    // internal memory bus side
    output logic                    mem_req,       // access request
    output logic                    mem_we,        // 1 write, 0 read
    output logic [ADDR_W-1:0]       mem_addr,      // byte address
    output logic [DATA_W-1:0]       mem_wdata,     // write byte
    input  wire logic               mem_ready,     // request accepted
    input  wire logic               mem_rvalid,    // read data valid
    input  wire logic [DATA_W-1:0]  mem_rdata      // read byte
);

    // one-hot sequencer states
    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,  // waiting for start
        ST_PRE  = 7'b0000010,  // leading overhead
        ST_RD   = 7'b0000100,  // issue source read
        ST_RDAT = 7'b0001000,  // catch read byte
        ST_WR   = 7'b0010000,  // issue destination write
        ST_UPD  = 7'b0100000,  // step pointers and counter
        ST_POST = 7'b1000000   // trailing overhead
    } move_state_e;

    localparam logic [PHASE_W-1:0] PRE_LAST  = PHASE_W'(PRE_STATES - 1);
    localparam logic [PHASE_W-1:0] POST_LAST = PHASE_W'(POST_STATES - 1);

    // sequencer state
    move_state_e         state;       // present state
    move_state_e         next_state;  // state for next edge
    logic [PHASE_W-1:0]  phase;       // overhead state counter

    // counter control
    logic                narrow;      // byte form latched at start
    logic                cnt_zero;    // active counter is zero
    logic                cnt_load;    // load counter at start
    logic                cnt_dec;     // one byte done

    // byte buffer handshake
    logic                fifo_in_ready;  // buffer has room
    logic                fifo_out_valid; // buffer holds a byte
    logic [DATA_W-1:0]   fifo_out_data;  // oldest buffered byte
    logic                push;        // read byte into buffer
    logic                pop;         // buffered byte written out

    // overhead phase ends
    logic                phase_end_pre;  // last leading state
    logic                phase_end_post; // last trailing state

    // adds one step to a pointer, shared by both pointers
    // pointers wrap at the top of the address space
    function automatic logic [ADDR_W-1:0] advance(
        input logic [ADDR_W-1:0] p
    );
        advance = p + PTR_STEP;
    endfunction

    // the active counter: low byte alone or the whole word
    // byte form leaves the upper byte as loaded
    move_counter #(
        .WIDTH (COUNT_W),
        .LOW_W (COUNT_LOW_W)
    ) u_count (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .load       (cnt_load),
        .load_value (count_word_in),
        .narrow     (narrow),
        .dec        (cnt_dec),
        .value      (count_word),
        .is_zero    (cnt_zero)
    );

    // buffer between the read and write halves of a byte;
    // a full buffer holds the read back, an empty one the write
    byte_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (mem_rdata),
        .out_valid (fifo_out_valid),
        .out_ready (pop),
        .out_data  (fifo_out_data)
    );

    // a start is taken only in idle; busy refuses the rest
    assign cnt_load       = (state == ST_IDLE) && start;
    assign cnt_dec        = (state == ST_UPD);

    // ends of the two overhead phases
    assign phase_end_pre  = (phase == PRE_LAST);
    assign phase_end_post = (phase == POST_LAST);

    // status seen by the decode side
    assign busy           = (state != ST_IDLE);
    assign done           = (state == ST_POST) && phase_end_post;

    // a read byte enters the buffer as soon as it returns
    assign push = (state == ST_RDAT) && mem_rvalid;
    // the write leaves the buffer once the bus takes it
    assign pop  = (state == ST_WR) && mem_ready && fifo_out_valid;

    // bus request decode; handshake outputs are combinational
    always_comb begin
        // defaults: no access, source on the address
        mem_req   = 1'b0;
        mem_we    = 1'b0;
        mem_addr  = source_pointer;
        mem_wdata = fifo_out_data;

        case (state)
            ST_RD: begin
                // read waits for buffer room so no byte is dropped
                mem_req  = fifo_in_ready;
                mem_addr = source_pointer;
            end

            ST_WR: begin
                // write only after its byte is buffered
                mem_req  = fifo_out_valid;
                mem_we   = 1'b1;
                mem_addr = dest_pointer;
            end

            default: begin
                // overhead and update keep off the bus
                mem_req  = 1'b0;
            end
        endcase
    end

    // next state; with single cycle memory each byte is four states
    always_comb begin
        // hold unless a branch below moves on
        next_state = state;

        case (state)
            ST_IDLE: begin
                // only idle looks at start
                if (start) begin
                    next_state = ST_PRE;
                end
            end

            ST_PRE: begin
                // counter checked at the end of the leading overhead
                if (phase_end_pre) begin
                    if (cnt_zero) begin
                        next_state = ST_POST;
                    end else begin
                        next_state = ST_RD;
                    end
                end
            end

            ST_RD: begin
                // slower memory simply holds this state longer
                if (mem_req && mem_ready) begin
                    next_state = ST_RDAT;
                end
            end

            ST_RDAT: begin
                // waits as long as the read data is late
                if (mem_rvalid) begin
                    next_state = ST_WR;
                end
            end

            ST_WR: begin
                // moves on once the bus takes the byte
                if (pop) begin
                    next_state = ST_UPD;
                end
            end

            ST_UPD: begin
                // the counter still holds the pre-decrement value;
                // one means this byte was the last one
                if (narrow ? (count_word[COUNT_LOW_W-1:0]
                              == COUNT_STEP[COUNT_LOW_W-1:0])
                           : (count_word == COUNT_STEP)) begin
                    next_state = ST_POST;
                end else begin
                    next_state = ST_RD;
                end
            end

            ST_POST: begin
                // done marks the last of these states
                if (phase_end_post) begin
                    next_state = ST_IDLE;
                end
            end

            default: begin
                // a broken one-hot code recovers to idle
                next_state = ST_IDLE;
            end
        endcase
    end

    // state register
    // reset parks the machine in idle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // overhead counter, cleared on entry to each overhead phase
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            phase <= '0;
        end else if ((state == ST_PRE) || (state == ST_POST)) begin
            // leaving a phase clears it for the next
            if (next_state != state) begin
                phase <= '0;
            end else begin
                phase <= phase + 1'b1;
            end
        end else begin
            // byte states and idle keep it at zero
            phase <= '0;
        end
    end

    // form of the move, held for the whole instruction
    // a start refused while busy cannot change it
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            narrow <= 1'b1;
        end else if (cnt_load) begin
            narrow <= !word_form;
        end
    end

    // source pointer: loaded at start, stepped once per byte
    // stepped in the update state, after the write is taken
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            source_pointer <= PTR_RESET;
        end else if (cnt_load) begin
            source_pointer <= src_in;
        end else if (state == ST_UPD) begin
            source_pointer <= advance(source_pointer);
        end
    end

    // destination pointer: a zero count never reaches ST_UPD,
    // so both pointers leave as they came
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            dest_pointer <= PTR_RESET;
        end else if (cnt_load) begin
            dest_pointer <= dst_in;
        end else if (state == ST_UPD) begin
            dest_pointer <= advance(dest_pointer);
        end
    end
endmodule
`default_nettype wire

// ### block_move_sequencer_sva.sv
// Purpose: port checker for the block move sequencer
// Assumes: one state per core_clk cycle
// Notes:   bound to every instance of the sequencer
`timescale 1ns/1ps
`default_nettype none
module block_move_sequencer_sva
    import block_move_pkg::*;
(
    input wire logic               core_clk,       // state clock
    input wire logic               nrst,           // async reset, low
    input wire logic               start,          // begin move
    input wire logic               word_form,      // 1 word form
    input wire logic [COUNT_W-1:0] count_word_in,  // counter at start
    input wire logic [ADDR_W-1:0]  src_in,         // source at start
    input wire logic [ADDR_W-1:0]  dst_in,         // dest at start
    input wire logic               busy,           // move running
    input wire logic               done,           // last state
    input wire logic [COUNT_W-1:0] count_word,     // live counter
    input wire logic [ADDR_W-1:0]  source_pointer, // live source
    input wire logic [ADDR_W-1:0]  dest_pointer,   // live dest
    input wire logic               mem_req,        // access request
    input wire logic               mem_we,         // 1 write
    input wire logic [ADDR_W-1:0]  mem_addr,       // byte address
    input wire logic [DATA_W-1:0]  mem_wdata,      // write byte
    input wire logic               mem_ready,      // accepted
    input wire logic               mem_rvalid,     // read byte valid
    input wire logic [DATA_W-1:0]  mem_rdata       // read byte
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    logic              form_q;   // form of the running move
    logic              rd_wait;  // read accepted, byte not back yet
    logic [DATA_W-1:0] rd_byte;  // last byte fetched
    logic              zero_in;  // starting count is zero
    logic              zero_now; // active count is zero
    assign zero_in  = word_form ? count_word_in == COUNT_ZERO
                                : count_word_in[7:0] == 8'h00;
    assign zero_now = form_q ? count_word == COUNT_ZERO
                             : count_word[7:0] == 8'h00;
    // shadow the form and the byte in flight, so write data can be tied
    // to what the read returned rather than to internal storage
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            form_q  <= 1'b0;
            rd_wait <= 1'b0;
            rd_byte <= 8'h00;
        end else begin
            if (start && !busy) begin
                form_q <= word_form;
            end
            if (mem_req && !mem_we && mem_ready) begin
                rd_wait <= 1'b1;
            end else if (mem_rvalid) begin
                rd_wait <= 1'b0;
            end
            if (rd_wait && mem_rvalid) begin
                rd_byte <= mem_rdata;
            end
        end
    end
    sequence s_take;
        start && !busy;
    endsequence
    sequence s_wr_acc;
        mem_req && mem_we && mem_ready;
    endsequence
    a_take_busy: assert property (s_take |=> busy)
        else $error("busy did not rise after start");
    a_zero_skip: assert property (s_take ##0 zero_in
        |=> (!mem_req)[*7] ##1 (done && !mem_req))
        else $error("zero count move not done in eight quiet states");
    a_done_drops: assert property (done |-> busy ##1 !busy)
        else $error("busy not released right after done");
    a_last_done: assert property (s_wr_acc ##2 zero_now |-> ##3 done)
        else $error("trailing states after last byte not four");
    a_next_read: assert property (s_wr_acc ##2 !zero_now
        |-> mem_req && !mem_we)
        else $error("next byte read did not follow update");
    a_ptr_step: assert property (s_wr_acc |-> ##2
        (source_pointer == $past(source_pointer, 2) + PTR_STEP &&
         dest_pointer == $past(dest_pointer, 2) + PTR_STEP))
        else $error("pointers did not step by one");
    a_count_step: assert property (s_wr_acc |-> ##2
        count_word == $past(count_word, 2) - COUNT_STEP)
        else $error("counter did not step down by one");
    a_read_src: assert property (mem_req && !mem_we
        |-> mem_addr == source_pointer)
        else $error("read not at source pointer");
    a_write_dst: assert property (mem_req && mem_we
        |-> mem_addr == dest_pointer && mem_wdata == rd_byte)
        else $error("write not the fetched byte at dest pointer");
    a_req_hold: assert property (mem_req && !mem_ready
        |=> mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("request changed before acceptance");
    a_idle_quiet: assert property (!busy |-> !mem_req && !done)
        else $error("bus activity while idle");
endmodule
bind block_move_sequencer block_move_sequencer_sva i_sva (
    .core_clk(core_clk), .nrst(nrst), .start(start),
    .word_form(word_form), .count_word_in(count_word_in),
    .src_in(src_in), .dst_in(dst_in), .busy(busy), .done(done),
    .count_word(count_word), .source_pointer(source_pointer),
    .dest_pointer(dest_pointer), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ready(mem_ready),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
`default_nettype wire

// ### move_memory_model.sv
// Purpose: internal memory bus model for the block move
// Assumes: one byte per access, read data one state after accept, two when slow
// Notes:   slow mode answers only every second cycle
`timescale 1ns/1ps
`default_nettype none
module move_memory_model
    import block_move_pkg::*;
(
    input  wire logic              core_clk,   // state clock
    input  wire logic              nrst,       // async reset, low
    input  wire logic              slow,       // 1 inserts wait states
    input  wire logic              mem_req,    // access request
    input  wire logic              mem_we,     // 1 write, 0 read
    input  wire logic [ADDR_W-1:0] mem_addr,   // byte address
    input  wire logic [DATA_W-1:0] mem_wdata,  // write byte
    output logic                   mem_ready,  // request accepted
    output logic                   mem_rvalid, // read byte valid
    output logic [DATA_W-1:0]      mem_rdata   // read byte
);
    logic [DATA_W-1:0] mem [0:65535]; // whole byte space
    logic              tick;          // wait state phase
    logic              pend;          // read accepted, byte owed
    logic [DATA_W-1:0] rd_byte;       // byte to return
    int                writes;        // accepted writes so far
    // neighbours differ, except 7FFF/8000 and FFFF/0000, so a wrong address shows up in the copy
    initial begin
        writes = 0;
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5A;
        end
    end
    // zero-wait answers only when fast; counts are exact only then
    assign mem_ready  = mem_req && (!slow || tick);
    assign mem_rvalid = pend && (!slow || tick);
    // a released data bus shows the inverse, never a stale byte
    assign mem_rdata  = mem_rvalid ? rd_byte : ~rd_byte;
    // read side: capture the byte at accept, hand it over later
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tick    <= 1'b0;
            pend    <= 1'b0;
            rd_byte <= 8'h00;
        end else begin
            tick <= !tick;
            if (mem_req && !mem_we && mem_ready) begin
                pend    <= 1'b1;
                rd_byte <= mem[mem_addr];
            end else if (mem_rvalid) begin
                pend <= 1'b0;
            end
        end
    end
    // write side
    always @(posedge core_clk) begin
        if (mem_req && mem_we && mem_ready) begin
            mem[mem_addr] <= mem_wdata;
            writes++;
        end
    end
endmodule
`default_nettype wire

// ### block_move_sequencer_bench.sv
// Purpose: self-checking bench for the block move sequencer
// Assumes: memory model on the bus side, decode driven here
// Notes:   each run also retries start while busy, which must be ignored
`timescale 1ns/1ps
`default_nettype none
module block_move_sequencer_bench
    import block_move_pkg::*;
;
    logic core_clk, nrst, start, word_form, slow;  // bench driven
    logic busy, done, mem_req, mem_we, mem_ready, mem_rvalid; // flags
    logic [15:0] count_word_in, src_in, dst_in;    // move operands
    logic [15:0] count_word, source_pointer, dest_pointer, mem_addr;
    logic [7:0]  mem_wdata, mem_rdata;             // bus bytes
    int          mismatches, comparisons, cycles;  // tallies
    block_move_sequencer i_dut (.core_clk(core_clk), .nrst(nrst),
        .start(start), .word_form(word_form), .count_word_in(count_word_in),
        .src_in(src_in), .dst_in(dst_in), .busy(busy), .done(done),
        .count_word(count_word), .source_pointer(source_pointer),
        .dest_pointer(dest_pointer), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ready(mem_ready),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
    move_memory_model i_mem (.core_clk(core_clk), .nrst(nrst),
        .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ready(mem_ready),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
    always #2.5 core_clk = ~core_clk;
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // whole runs are short; this ceiling only catches a hang
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            report_and_stop();
        end
    end
    // one move: start, a refused second start, wait, then judge
    task automatic run_move(input logic form, input logic [15:0] cnt,
        input logic [15:0] src, dst, input int n, input logic fast);
        logic [7:0] want [$];
        int cyc;
        int w0;
        w0 = i_mem.writes;
        for (int i = 0; i < n; i++) begin
            want.push_back(i_mem.mem[16'(src + i)]);
        end
        @(posedge core_clk);
        start <= 1'b1;
        word_form <= form;
        count_word_in <= cnt;
        src_in <= src;
        dst_in <= dst;
        @(posedge core_clk);
        src_in <= ~src;
        cyc = 0;
        while (done !== 1'b1 && cyc < 2000) begin
            @(posedge core_clk);
            start <= 1'b0;
            #1;
            cyc++;
        end
        if (fast) check("states", cyc + 1, 8 + 4 * n);
        else check("stretched", cyc + 1 > 8 + 4 * n, 1);
        check("count", count_word, cnt - 16'(n));
        check("source", source_pointer, 16'(src + n));
        check("dest", dest_pointer, 16'(dst + n));
        check("writes", i_mem.writes - w0, n);
        for (int i = 0; i < n; i++) begin
            check("copy", i_mem.mem[16'(dst + i)], want[i]);
        end
        @(posedge core_clk);
        #1;
        check("busy", busy, 1'b0);
    endtask
    task automatic t_zero_count;
        run_move(1'b0, 16'h1200, 16'h0100, 16'h0200, 0, 1'b1);
        run_move(1'b1, 16'h0000, 16'h0100, 16'h0200, 0, 1'b1);
        $display("zero count done");
    endtask
    task automatic t_byte_form;
        run_move(1'b0, 16'hAB03, 16'hFFFF, 16'h0300, 3, 1'b1);
        $display("byte form done");
    endtask
    task automatic t_word_form;
        run_move(1'b1, 16'h0100, 16'h1000, 16'h2000, 256, 1'b1);
        $display("word form done");
    endtask
    task automatic t_slow_memory;
        slow <= 1'b1;
        run_move(1'b0, 16'h0002, 16'h0400, 16'h0500, 2, 1'b0);
        slow <= 1'b0;
        $display("slow memory done");
    endtask
    initial begin
        core_clk = 1'b0;
        nrst = 1'b0;
        start = 1'b0;
        word_form = 1'b0;
        slow = 1'b0;
        count_word_in = 16'h0000;
        src_in = 16'h0000;
        dst_in = 16'h0000;
        mismatches = 0;
        comparisons = 0;
        cycles = 0;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        t_zero_count();
        t_byte_form();
        t_word_form();
        t_slow_memory();
        report_and_stop();
    end
endmodule
`default_nettype wire
